// ### rtl/host_bus_pkg.sv
// Constants shared by the host bus width and select logic.
// Assumes a single 20 MHz clock; no software-visible register map.
package host_bus_pkg;
    // Clock period in nanoseconds
    localparam int CLK_PERIOD_NS = 50;
    // Ready negation length in clock periods: two to three, we hold three
    localparam int RDY_LOW_MIN_CYC = 2;
    localparam int RDY_LOW_CYC = 3;
    // Transmit indicator least pulse width, microseconds
    localparam int TX_IND_MIN_US = 314;
    // Least time rounds up to whole cycles
    localparam int TX_IND_CYC = (TX_IND_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Configuration byte field positions
    localparam int CFG_WIDE_BIT = 7;
    localparam int CFG_WAIT_BIT = 6;
    // Buffer pointer width and word step
    localparam int PTR_W = 11;
    localparam logic [10:0] PTR_STEP = 11'h002;
    // Default select windows (upper address compare values)
    localparam logic [8:0] MEM_BASE_DEF = 9'h19A;
    localparam logic [13:0] IO_BASE_DEF = 14'h00B8;
    // Ready stretch states
    typedef enum logic [2:0] {
        RDY_IDLE = 3'b001,
        RDY_HOLD = 3'b010,
        RDY_DONE = 3'b100
    } rdy_state_e;
endpackage : host_bus_pkg

// ### rtl/host_bus_width_and_select.sv
// Host bus width detection, 16-bit select decode, ready stretch,
// strobe address capture, I/O pointer stepping and transmit indicator.
// Assumes all host strobes and addresses are synchronous to clk.
// Summary of operation
// RULE_01 - Low sense before config write selects 16-bit
// RULE_02 - Config write overrides sensed width
// RULE_03 - Width bit shows sensed default until written
// RULE_04 - Memory select from raw A19-A11 compare
// RULE_05 - I/O select from raw A15-A2 compare
// RULE_06 - Ready negated two to three clocks
// RULE_07 - Address captured on read/write strobe lead
// RULE_08 - Latch strobe tied high in 8-bit mode
// RULE_09 - I/O data access steps pointer by two; code steps it only while the 16-bit width bit is set
// RULE_10 - Wait bit zero keeps ready asserted
// RULE_11 - Bit 7 is the 16-bit enable
// RULE_12 - Transmit indicator pulse at least 314 us
// RULE_13 - Host avoids odd byte writes in I/O mode
// RULE_14 - Sense synchronised, sticky low flag frozen
module host_bus_width_and_select
    import host_bus_pkg::*;
#(
    parameter logic [8:0] MEM_BASE = MEM_BASE_DEF,
    parameter logic [13:0] IO_BASE = IO_BASE_DEF,
    parameter int TX_CYCLES = TX_IND_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic bus_size_sense_n,
    input wire logic [19:0] addr,
    input wire logic bale,
    input wire logic aen,
    input wire logic memr_n,
    input wire logic memw_n,
    input wire logic ior_n,
    input wire logic iow_n,
    input wire logic cfg_write,
    input wire logic [7:0] cfg_data,
    input wire logic io_data_access,
    input wire logic internal_access,
    input wire logic tx_start,
    output logic wide_bus_enable_bit,
    output logic wait_enable,
    output logic memcs16_n,
    output logic iocs16_n,
    output logic iochrdy,
    output logic [19:0] latched_addr,
    output logic [PTR_W-1:0] buf_ptr,
    output logic transmit_activity_indicator
);
    // Match of upper memory lines against the window base
    function automatic logic mem_hit(input logic [19:0] a, input logic [8:0] base);
        mem_hit = (a[19:11] == base);
    endfunction : mem_hit

    // Match of I/O lines against the port base
    function automatic logic io_hit(input logic [19:0] a, input logic [13:0] base);
        io_hit = (a[15:2] == base);
    endfunction : io_hit

    // Sense synchroniser; first stage read only by the second
    logic sense_s1;
    logic sense_s2;
    // Sticky low-seen flag and freeze after first config write
    logic low_seen;
    logic next_low_seen;
    logic cfg_written;
    logic next_cfg_written;
    // Software-written width and wait bits
    logic sw_wide;
    logic next_sw_wide;
    logic next_wait_enable;

    // Two-stage synchroniser on the sense input
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sense_s1 <= 1'b1;
            sense_s2 <= 1'b1;
        end else begin
            sense_s1 <= bus_size_sense_n; // RULE_14
            sense_s2 <= sense_s1;
        end
    end

    // Width detection and configuration next state
    always_comb begin
        next_low_seen = low_seen;
        next_cfg_written = cfg_written;
        next_sw_wide = sw_wide;
        next_wait_enable = wait_enable;
        // Any low seen before the first write sets the flag
        if (!cfg_written && !sense_s2) begin
            next_low_seen = 1'b1; // RULE_01
        end
        if (cfg_write) begin
            next_cfg_written = 1'b1; // RULE_14
            next_sw_wide = cfg_data[CFG_WIDE_BIT]; // RULE_02
            next_wait_enable = cfg_data[CFG_WAIT_BIT];
        end
    end

    // Configuration registers; wait stretching enabled out of reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_seen <= 1'b0;
            cfg_written <= 1'b0;
            sw_wide <= 1'b0;
            wait_enable <= 1'b1;
        end else begin
            low_seen <= next_low_seen;
            cfg_written <= next_cfg_written;
            sw_wide <= next_sw_wide;
            wait_enable <= next_wait_enable;
        end
    end

    // Bit 7 reflects detection until software writes it
    assign wide_bus_enable_bit = cfg_written ? sw_wide : low_seen; // RULE_03 RULE_11

    // Selects decode the raw address, not the latched copy, so they
    // track the bus without waiting for the latch strobe
    assign memcs16_n = ~(wide_bus_enable_bit & mem_hit(addr, MEM_BASE)); // RULE_04
    assign iocs16_n = ~(wide_bus_enable_bit & ~aen & io_hit(addr, IO_BASE)); // RULE_05

    // Strobe edge detection
    logic memr_d;
    logic memw_d;
    logic ior_d;
    logic iow_d;
    logic mem_lead;
    logic io_lead;
    logic io_trail;
    logic [19:0] next_latched_addr;

    assign mem_lead = (memr_d & ~memr_n) | (memw_d & ~memw_n);
    assign io_lead = (ior_d & ~ior_n) | (iow_d & ~iow_n);
    assign io_trail = (~ior_d & ior_n) | (~iow_d & iow_n);

    // Address capture ignores bale, so a tied-high latch strobe in
    // 8-bit mode still addresses both halves of a split cycle
    always_comb begin
        next_latched_addr = latched_addr;
        if (mem_lead || io_lead) begin
            next_latched_addr = addr; // RULE_07 RULE_08
        end
    end

    // Strobe history and latched address
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            memr_d <= 1'b1;
            memw_d <= 1'b1;
            ior_d <= 1'b1;
            iow_d <= 1'b1;
            latched_addr <= 20'h00000;
        end else begin
            memr_d <= memr_n;
            memw_d <= memw_n;
            ior_d <= ior_n;
            iow_d <= iow_n;
            latched_addr <= next_latched_addr;
        end
    end

    // Buffer pointer steps by two after each I/O data word access
    logic [PTR_W-1:0] next_buf_ptr;
    always_comb begin
        next_buf_ptr = buf_ptr;
        if (io_trail && io_data_access && wide_bus_enable_bit) begin
            next_buf_ptr = buf_ptr + PTR_STEP; // RULE_09
        end
    end

    // Pointer register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            buf_ptr <= '0;
        end else begin
            buf_ptr <= next_buf_ptr;
        end
    end

    // Ready stretch machine
    rdy_state_e rdy_state;
    rdy_state_e next_rdy_state;
    logic [1:0] rdy_cnt;
    logic [1:0] next_rdy_cnt;
    logic access_start;

    assign access_start = (mem_lead | io_lead) & internal_access;

    // Negation lasts RDY_LOW_CYC clocks, inside the two-to-three span
    always_comb begin
        next_rdy_state = rdy_state;
        next_rdy_cnt = rdy_cnt;
        case (rdy_state)
            RDY_IDLE: begin
                // Wait bit cleared means no negation at all
                if (access_start && wait_enable) begin // RULE_10
                    next_rdy_state = RDY_HOLD;
                    next_rdy_cnt = 2'(RDY_LOW_CYC - 1);
                end
            end
            RDY_HOLD: begin
                if (rdy_cnt == 2'h0) begin
                    next_rdy_state = RDY_DONE; // RULE_06
                end else begin
                    next_rdy_cnt = rdy_cnt - 2'h1;
                end
            end
            RDY_DONE: begin
                // Wait for the strobes to end before rearming
                if (memr_n && memw_n && ior_n && iow_n) begin
                    next_rdy_state = RDY_IDLE;
                end
            end
            default: begin
                next_rdy_state = RDY_IDLE;
            end
        endcase
    end

    // Ready state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdy_state <= RDY_IDLE;
            rdy_cnt <= 2'h0;
        end else begin
            rdy_state <= next_rdy_state;
            rdy_cnt <= next_rdy_cnt;
        end
    end

    // Ready low exactly while holding
    assign iochrdy = (rdy_state != RDY_HOLD); // RULE_06

    // Transmit indicator stretcher
    pulse_stretch #(
        .CYCLES(TX_CYCLES)
    ) u_tx_ind (
        .clk(clk),
        .rst(rst),
        .trigger(tx_start),
        .pulse_n(transmit_activity_indicator)
    );
endmodule : host_bus_width_and_select

// ### rtl/pulse_stretch.sv
// Stretches a one-cycle trigger into an active-low pulse of fixed least length.
// Assumes trigger is synchronous to clk.
module pulse_stretch
    import host_bus_pkg::*;
#(
    parameter int CYCLES = TX_IND_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic trigger,
    output logic pulse_n
);
    // Remaining cycles of the pulse
    logic [19:0] count;
    logic [19:0] next_count;

    // Retrigger restarts the full length so no pulse is ever short
    always_comb begin
        next_count = count;
        if (trigger) begin
            next_count = 20'(CYCLES);
        end else if (count != 20'h00000) begin
            next_count = count - 20'h00001;
        end
    end

    // Count register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= 20'h00000;
        end else begin
            count <= next_count;
        end
    end

    // Output from a flip-flop so it carries no glitch
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pulse_n <= 1'b1;
        end else begin
            pulse_n <= (next_count == 20'h00000); // RULE_12
        end
    end
endmodule : pulse_stretch

// ### test/host_bus_width_and_select_monitor.sv
// Port checker for the host bus width and select block.
// Assumes one clock domain; bound to every instance below.
module host_bus_width_and_select_monitor
    import host_bus_pkg::*;
#(
    parameter logic [8:0] MEM_BASE = MEM_BASE_DEF,
    parameter logic [13:0] IO_BASE = IO_BASE_DEF,
    parameter int TX_CYCLES = TX_IND_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [19:0] addr,
    input wire logic aen,
    input wire logic memr_n,
    input wire logic memw_n,
    input wire logic ior_n,
    input wire logic iow_n,
    input wire logic cfg_write,
    input wire logic [7:0] cfg_data,
    input wire logic io_data_access,
    input wire logic tx_start,
    input wire logic wide_bus_enable_bit,
    input wire logic wait_enable,
    input wire logic memcs16_n,
    input wire logic iocs16_n,
    input wire logic iochrdy,
    input wire logic [19:0] latched_addr,
    input wire logic [PTR_W-1:0] buf_ptr,
    input wire logic transmit_activity_indicator
);
    // Width bit as written; a plain net keeps $past on a signal
    wire logic cfg_wide = cfg_data[CFG_WIDE_BIT];
    // I/O strobe trailing edge drives the pointer
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_mem_sel_decode: assert property (memcs16_n == !(wide_bus_enable_bit
        && addr[19:11] == MEM_BASE)) else $error("mem select wrong");
    a_io_sel_decode: assert property (iocs16_n == !(wide_bus_enable_bit && !aen
        && addr[15:2] == IO_BASE)) else $error("io select wrong");
    a_ready_low_len: assert property ($fell(iochrdy) |-> !iochrdy[*3] ##1 iochrdy)
        else $error("ready stretch length");
    a_no_wait_ready: assert property (!wait_enable |-> iochrdy)
        else $error("ready negated without wait");
    a_strobe_addr_capture: assert property (($fell(memr_n) || $fell(memw_n))
        |=> latched_addr == $past(addr)) else $error("address not captured");
    a_ptr_word_step: assert property (($rose(ior_n) || $rose(iow_n)) && io_data_access
        && wide_bus_enable_bit |=> buf_ptr == $past(buf_ptr) + PTR_STEP)
        else $error("pointer step wrong");
    a_ptr_hold_idle: assert property (!($rose(ior_n) || $rose(iow_n)) |=> $stable(buf_ptr))
        else $error("pointer moved");
    a_tx_start_low: assert property (tx_start |=> !transmit_activity_indicator)
        else $error("indicator not started");
    a_width_write: assert property (cfg_write |=> wide_bus_enable_bit == $past(cfg_wide))
        else $error("width not overridden");
    c_ready_stretch: cover property ($fell(iochrdy));
    c_tx_end: cover property ($rose(transmit_activity_indicator));
    c_ptr_step: cover property (($rose(ior_n) || $rose(iow_n)) && io_data_access);
endmodule : host_bus_width_and_select_monitor

bind host_bus_width_and_select host_bus_width_and_select_monitor #(.MEM_BASE(MEM_BASE),
    .IO_BASE(IO_BASE), .TX_CYCLES(TX_CYCLES)) mon (.clk(clk), .rst(rst), .addr(addr),
    .aen(aen), .memr_n(memr_n), .memw_n(memw_n), .ior_n(ior_n), .iow_n(iow_n),
    .cfg_write(cfg_write), .cfg_data(cfg_data), .io_data_access(io_data_access),
    .tx_start(tx_start), .wide_bus_enable_bit(wide_bus_enable_bit),
    .wait_enable(wait_enable), .memcs16_n(memcs16_n), .iocs16_n(iocs16_n),
    .iochrdy(iochrdy), .latched_addr(latched_addr), .buf_ptr(buf_ptr),
    .transmit_activity_indicator(transmit_activity_indicator));

// ### test/host_isa_model.sv
// Host processor model: one word cycle per go pulse.
// Assumes go and kind are set by non-blocking assignment on the falling edge.
module host_isa_model (
    input wire logic clk,
    input wire logic go,
    input wire logic [1:0] kind,
    input wire logic [19:0] a,
    input wire logic iochrdy,
    output logic [19:0] addr,
    output logic memr_n,
    output logic memw_n,
    output logic ior_n,
    output logic iow_n,
    output logic bale,
    output logic done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] st = 2'h0; // Cycle phase
    logic [2:0] n = 3'h0; // Strobe-low age; ready is trusted only once it could have fallen
    assign bale = 1'b1;
    initial {addr, memr_n, memw_n, ior_n, iow_n, done} = {20'h00000, 4'hF, 1'b0};
    // Address first, strobe next, hold until ready was sampled high, then release
    always @(negedge clk) begin
        done <= 1'b0;
        if (st == 2'h0 && go) begin
            addr <= a;
            st <= 2'h1;
        end else if (st == 2'h1) begin
            // Word cycles only, never an odd byte write
            {iow_n, ior_n, memw_n, memr_n} <= ~(4'h1 << kind);
            n <= 3'h0;
            st <= 2'h2;
        end else if (st == 2'h2) begin
            n <= n + 3'h1;
            if (n >= 3'h2 && iochrdy) st <= 2'h3;
        end else if (st == 2'h3) begin
            {iow_n, ior_n, memw_n, memr_n} <= 4'hF;
            addr <= ~addr; // Released bus shows no stale address
            done <= 1'b1;
            st <= 2'h0;
        end
    end
endmodule : host_isa_model

// ### test/test_host_bus_width_and_select.sv
// Testbench: width sensing, selects, ready stretch, capture, pointer, indicator.
// Assumes the host model and the bound checker sit beside the design.
module test_host_bus_width_and_select import host_bus_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, sense_n = 1, aen = 0, cfg_write = 0, ioda = 0, intacc = 0;
    logic tx_start = 0, go = 0, ew = 0, ewt = 1, done;
    logic [7:0] cfg_data = 8'h00;
    logic [1:0] kind = 2'h0;
    logic [19:0] a = 20'h00000, addr, la;
    logic [10:0] ep = 11'h000, ptr;
    logic memr_n, memw_n, ior_n, iow_n, bale, wide, wen, m16, i16, rdy, tai;
    int mismatches = 0, checks = 0, lowc, i, k;
    initial forever #25 clk = ~clk;
    host_bus_width_and_select #(.TX_CYCLES(20)) dut (.clk(clk), .rst(rst),
        .bus_size_sense_n(sense_n), .addr(addr), .bale(bale), .aen(aen), .memr_n(memr_n),
        .memw_n(memw_n), .ior_n(ior_n), .iow_n(iow_n), .cfg_write(cfg_write),
        .cfg_data(cfg_data), .io_data_access(ioda), .internal_access(intacc),
        .tx_start(tx_start), .wide_bus_enable_bit(wide), .wait_enable(wen),
        .memcs16_n(m16), .iocs16_n(i16), .iochrdy(rdy), .latched_addr(la), .buf_ptr(ptr),
        .transmit_activity_indicator(tai));
    host_isa_model host (.clk(clk), .go(go), .kind(kind), .a(a), .iochrdy(rdy),
        .addr(addr), .memr_n(memr_n), .memw_n(memw_n), .ior_n(ior_n), .iow_n(iow_n),
        .bale(bale), .done(done));
    // Expected select levels from the raw address and the width bit
    function automatic logic exp_mcs_n(input logic w, input logic [19:0] ad);
        return !(w && ad[19:11] == MEM_BASE_DEF);
    endfunction : exp_mcs_n
    function automatic logic exp_ics_n(input logic w, input logic en, input logic [19:0] ad);
        return !(w && !en && ad[15:2] == IO_BASE_DEF);
    endfunction : exp_ics_n
    task chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task give_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    task cfg(input logic [7:0] d);
        @(negedge clk) {cfg_data, cfg_write} = {d, 1'b1};
        @(negedge clk) cfg_write = 0;
    endtask : cfg
    task sense_low;
        @(negedge clk) sense_n = 0;
        @(negedge clk) sense_n = 1;
        repeat (5) @(negedge clk);
    endtask : sense_low
    // One random host cycle; selects checked mid-cycle, ready low time counted
    task rnd_acc;
        logic [19:0] ad;
        ad = 20'($urandom);
        if ($urandom % 2) ad[19:11] = MEM_BASE_DEF;
        if ($urandom % 2) ad[15:2] = IO_BASE_DEF;
        @(negedge clk) {kind, a, go} <= {2'($urandom), ad, 1'b1};
        {aen, ioda, intacc} <= 3'($urandom);
        @(negedge clk) go <= 0;
        lowc = 0;
        for (k = 0; k < 40 && !done; k++) begin
            @(posedge clk);
            if (!rdy) lowc++;
            if (k == 3) begin
                chk("memcs16_n", m16, exp_mcs_n(ew, ad));
                chk("iocs16_n", i16, exp_ics_n(ew, aen, ad));
            end
        end
        if (!done) begin
            mismatches++;
            give_verdict;
        end
        chk("ready low cycles", lowc, (ewt && intacc) ? 3 : 0);
        @(posedge clk);
        @(negedge clk);
        if (!kind[1]) chk("latched_addr", la, ad);
        if (kind[1] && ew && ioda) ep = ep + 11'h002;
        chk("buf_ptr", ptr, ep);
    endtask : rnd_acc
    initial begin
        k = $urandom(67);
        repeat (16) @(posedge clk);
        @(negedge clk) rst = 0;
        repeat (5) @(negedge clk);
        chk("width high sense", wide, 0);
        sense_low;
        chk("width low sense", wide, 1);
        cfg(8'h00);
        {ew, ewt} = 2'b00;
        sense_low;
        chk("width frozen", wide, 0);
        chk("wait bit", wen, 0);
        for (i = 0; i < 8; i++) rnd_acc;
        cfg(8'hC0);
        {ew, ewt} = 2'b11;
        chk("width written", wide, 1);
        for (i = 0; i < 40; i++) rnd_acc;
        @(negedge clk) tx_start = 1;
        @(negedge clk) tx_start = 0;
        lowc = 0;
        for (k = 0; k < 60; k++) @(posedge clk) lowc += !tai;
        chk("indicator low cycles", lowc, 20);
        give_verdict;
    end
endmodule : test_host_bus_width_and_select
